// ===== pkg/sber_cfg.svh
// Constants for the security-banked exception routing block.
// Assumes inclusion by the package only.
`ifndef SBER_CFG_SVH
`define SBER_CFG_SVH
`define SBER_INTERRUPT_CONTROL_STATE_REGISTER_TTNS_POS   24
`define SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS   28
`define SBER_INTERRUPT_CONTROL_STATE_REGISTER_PCLR_POS   27
`define SBER_EXR_SKIP_POS    5
`define SBER_EXR_MODE_POS    3
`define SBER_EXR_SPSEL_POS   2
`define SBER_EXR_BASE        32'hffffff80
`define SBER_EXTRA_FRAME_OFS 32'h00000040
`define SBER_PRI_RESET       8'h00
`define SBER_TTNS_RESET      1'b0
`define SBER_PRI_W           8
`define SBER_SIG_MSB_MASK    32'hfffffff0
`define SBER_SIG_VALUE       32'hfefa1250
`endif

// ===== pkg/sber_pkg.sv
// Types for the security-banked exception routing block.
// Assumes the cfg header is found on the include path.
`include "sber_cfg.svh"
package sber_pkg;
  typedef enum logic [1:0] {
    SBER_MPU_NONE = 2'h0,
    SBER_MPU_SEC  = 2'h1,
    SBER_MPU_NS   = 2'h3,
    SBER_MPU_BOTH = 2'h2
  } sber_mpu_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic        write;
    logic        priv;
    logic        cur_ns;
    logic        addr_ns;
    logic [31:0] addr;
  } sber_acc_t;

  typedef struct packed {
    logic valid;
    logic use_sec;
    logic use_ns;
    logic fault_sec;
    logic fault_ns;
    logic sig_fault;
  } sber_chk_t;

  typedef struct packed {
    logic        we;
    logic        from_sec;
    logic        ns_alias;
    logic [31:0] wdata;
  } sber_interrupt_control_state_register_wr_t;

  typedef enum logic [1:0] {
    SBER_ST_IDLE = 2'h0,
    SBER_ST_CALL = 2'h1,
    SBER_ST_RET  = 2'h3
  } sber_state_t;
endpackage

// ===== logic/sber_core.sv
// Security-banked exception routing: banked call and pendable service
// exceptions, return code, tick targeting, protection unit selection.
// Assumes one core clock and software as the only outside party.
`timescale 1ns/100ps
module sber_core
  import sber_pkg::*;
#(
  parameter bit            TWO_TICKS = 1'b0,
  parameter sber_mpu_cfg_t MPU_CFG   = SBER_MPU_BOTH,
  parameter int            SEC_REGS  = 8,
  parameter int            NS_REGS   = 8
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  cur_ns,
  input  wire logic                  supervisor_call_instruction,
  input  wire logic                  extra_stacking_done,
  input  wire logic                  exc_take,
  input  wire logic                  exc_to_ns,
  input  wire logic                  ret_mode_thread,
  input  wire logic                  ret_spsel_psp,
  input  wire logic [31:0]           stack_ptr,
  input  wire sber_pkg::sber_interrupt_control_state_register_wr_t interrupt_control_state_register_wr,
  input  wire logic                  pri_we,
  input  wire logic                  pri_ns,
  input  wire logic [7:0]            pri_call,
  input  wire logic [7:0]            pri_serv,
  input  wire logic                  tick_sec_event,
  input  wire logic                  tick_ns_event,
  input  wire sber_pkg::sber_acc_t   acc,
  input  wire logic                  sec_unit_fault,
  input  wire logic                  ns_unit_fault,
  input  wire logic                  service_taken_sec,
  input  wire logic                  service_taken_ns,
  output logic [1:0]                 call_exc_r,
  output logic [1:0]                 serv_pend_r,
  output logic [1:0]                 tick_exc_r,
  output logic [7:0]                 pri_call_sec_r,
  output logic [7:0]                 pri_call_ns_r,
  output logic [7:0]                 pri_serv_sec_r,
  output logic [7:0]                 pri_serv_ns_r,
  output logic [31:0]                interrupt_control_state_register_rdata_r,
  output logic [31:0]                exception_return_code_r,
  output logic [31:0]                arg_frame_r,
  output sber_pkg::sber_chk_t        chk_r
);
  import sber_pkg::*;

  localparam bit HAS_SEC = (MPU_CFG == SBER_MPU_SEC) ||
                           (MPU_CFG == SBER_MPU_BOTH);
  localparam bit HAS_NS  = (MPU_CFG == SBER_MPU_NS) ||
                           (MPU_CFG == SBER_MPU_BOTH);

  // Bank mask: bit 1 is non-secure, bit 0 is secure
  function automatic logic [1:0] bank_sel(input logic ns);
    bank_sel = ns ? 2'h2 : 2'h1;
  endfunction

  logic        ttns_r;
  logic        ttns_nxt;
  logic [1:0]  call_nxt;
  logic [1:0]  pend_nxt;
  logic [1:0]  tick_nxt;
  logic [7:0]  pcs_nxt;
  logic [7:0]  pcn_nxt;
  logic [7:0]  pss_nxt;
  logic [7:0]  psn_nxt;
  logic [31:0] interrupt_control_state_register_nxt;
  logic [31:0] exr_nxt;
  logic [31:0] arg_nxt;
  sber_chk_t   chk_nxt;
  logic        wr_ns;
  logic        ttns_ok;
  logic        unit_ns;
  logic        sig_hit;

  always_comb begin
    // Secure software writes the non-secure bank through the alias
    wr_ns   = interrupt_control_state_register_wr.from_sec ? interrupt_control_state_register_wr.ns_alias : 1'b1;
    ttns_ok = interrupt_control_state_register_wr.from_sec && !interrupt_control_state_register_wr.ns_alias && !TWO_TICKS;
    call_nxt = supervisor_call_instruction ? bank_sel(cur_ns)
                                           : 2'h0;
    pend_nxt = serv_pend_r & ~{service_taken_ns, service_taken_sec};
    if (interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PCLR_POS]) begin
      pend_nxt = pend_nxt & ~bank_sel(wr_ns);
    end
    // Set wins over a clear in the same cycle
    if (interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS]) begin
      pend_nxt = pend_nxt | bank_sel(wr_ns);
    end
    ttns_nxt = ttns_r;
    if (interrupt_control_state_register_wr.we && ttns_ok) begin
      ttns_nxt = interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_TTNS_POS];
    end
    if (TWO_TICKS) begin
      tick_nxt = {tick_ns_event, tick_sec_event};
    end else begin
      tick_nxt = tick_sec_event ? bank_sel(ttns_r) : 2'h0;
    end
    pcs_nxt = pri_call_sec_r;
    pcn_nxt = pri_call_ns_r;
    pss_nxt = pri_serv_sec_r;
    psn_nxt = pri_serv_ns_r;
    if (pri_we && pri_ns) begin
      pcn_nxt = pri_call;
      psn_nxt = pri_serv;
    end else if (pri_we) begin
      pcs_nxt = pri_call;
      pss_nxt = pri_serv;
    end
    interrupt_control_state_register_nxt = 32'h0;
    interrupt_control_state_register_nxt[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS] =
      serv_pend_r[interrupt_control_state_register_wr.from_sec && !interrupt_control_state_register_wr.ns_alias ? 0 : 1];
    // Hidden target bit reads as zero
    interrupt_control_state_register_nxt[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_TTNS_POS] = ttns_ok & ttns_r;
    exr_nxt = exception_return_code_r;
    arg_nxt = arg_frame_r;
    if (exc_take) begin
      exr_nxt = `SBER_EXR_BASE;
      exr_nxt[0] = ~exc_to_ns;
      exr_nxt[6] = ~cur_ns;
      // Skip flag set unless extra state was stacked on a secure-to-secure entry
      exr_nxt[`SBER_EXR_SKIP_POS] =
        !(extra_stacking_done && !cur_ns && !exc_to_ns);
      exr_nxt[`SBER_EXR_MODE_POS]  = ret_mode_thread;
      exr_nxt[`SBER_EXR_SPSEL_POS] = ret_spsel_psp;
      arg_nxt = (extra_stacking_done && !cur_ns && !exc_to_ns)
              ? stack_ptr + `SBER_EXTRA_FRAME_OFS : stack_ptr;
    end
    // Fetch follows the address, data follows the request state
    unit_ns = acc.fetch ? acc.addr_ns : acc.cur_ns;
    sig_hit = acc.fetch && ((acc.addr & `SBER_SIG_MSB_MASK)
                            == `SBER_SIG_VALUE);
    chk_nxt = '0;
    chk_nxt.valid = acc.valid;
    if (acc.valid) begin
      chk_nxt.use_sec = !unit_ns && HAS_SEC;
      chk_nxt.use_ns  = unit_ns && HAS_NS;
      chk_nxt.fault_sec = (!unit_ns && HAS_SEC && sec_unit_fault) ||
                          sig_hit;
      chk_nxt.fault_ns  = unit_ns && HAS_NS && ns_unit_fault && !sig_hit;
      chk_nxt.sig_fault = sig_hit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ttns_r         <= `SBER_TTNS_RESET;
      call_exc_r     <= 2'h0;
      serv_pend_r    <= 2'h0;
      tick_exc_r     <= 2'h0;
      pri_call_sec_r <= `SBER_PRI_RESET;
      pri_call_ns_r  <= `SBER_PRI_RESET;
      pri_serv_sec_r <= `SBER_PRI_RESET;
      pri_serv_ns_r  <= `SBER_PRI_RESET;
      interrupt_control_state_register_rdata_r   <= 32'h0;
      exception_return_code_r   <= 32'h0;
      arg_frame_r    <= 32'h0;
      chk_r          <= '0;
    end else begin
      ttns_r         <= ttns_nxt;
      call_exc_r     <= call_nxt;
      serv_pend_r    <= pend_nxt;
      tick_exc_r     <= tick_nxt;
      pri_call_sec_r <= pcs_nxt;
      pri_call_ns_r  <= pcn_nxt;
      pri_serv_sec_r <= pss_nxt;
      pri_serv_ns_r  <= psn_nxt;
      interrupt_control_state_register_rdata_r   <= interrupt_control_state_register_nxt;
      exception_return_code_r   <= exr_nxt;
      arg_frame_r    <= arg_nxt;
      chk_r          <= chk_nxt;
    end
  end

  sequence s_call_in;
    supervisor_call_instruction;
  endsequence

  a_call_bank: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_call_in |=> call_exc_r == ($past(cur_ns) ? 2'h2 : 2'h1))
    else $error("Call exception in wrong state");
  a_pend_set: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS] && !interrupt_control_state_register_wr.from_sec
    |=> serv_pend_r[1])
    else $error("Non-secure pend set lost");
  a_pend_other: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && !interrupt_control_state_register_wr.from_sec && !service_taken_sec
    |=> serv_pend_r[0] == $past(serv_pend_r[0]))
    else $error("Non-secure write touched secure pend");
  a_pri_bank: assert property (@(posedge ref_clk) disable iff (!resetn)
    pri_we && pri_ns |=> $stable(pri_call_sec_r))
    else $error("Non-secure priority write hit secure bank");
  a_skip_flag: assert property (@(posedge ref_clk) disable iff (!resetn)
    exc_take && extra_stacking_done && !cur_ns && !exc_to_ns
    |=> !exception_return_code_r[`SBER_EXR_SKIP_POS] &&
        arg_frame_r == $past(stack_ptr) + 32'h40)
    else $error("Extra stacking not recorded");
  a_tick_single: assert property (@(posedge ref_clk) disable iff (!resetn)
    !TWO_TICKS && tick_sec_event && ttns_r |=> tick_exc_r == 2'h2)
    else $error("Tick not routed by target bit");
  a_ttns_hide: assert property (@(posedge ref_clk) disable iff (!resetn)
    !interrupt_control_state_register_wr.from_sec |=> !interrupt_control_state_register_rdata_r[24])
    else $error("Target bit visible outside secure");
  a_fetch_unit: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc.valid && acc.fetch && !acc.addr_ns && HAS_SEC
    |=> chk_r.use_sec && !chk_r.use_ns)
    else $error("Fetch not checked by secure unit");
  a_sig_fault: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc.valid && acc.fetch &&
    (acc.addr & 32'hfffffff0) == 32'hfefa1250
    |=> chk_r.fault_sec && chk_r.sig_fault)
    else $error("Signature return did not fault");

  // Entry cases that decide the frame layout, and the non-secure callable fetch case
  sequence s_extra_entry;
    exc_take && extra_stacking_done && !cur_ns && !exc_to_ns;
  endsequence

  sequence s_plain_entry;
    exc_take && !(extra_stacking_done && !cur_ns && !exc_to_ns);
  endsequence

  sequence s_ns_callable_fetch;
    acc.valid && acc.fetch && acc.cur_ns && !acc.addr_ns;
  endsequence

  a_skip_plain: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_plain_entry |=> exception_return_code_r[`SBER_EXR_SKIP_POS] &&
        arg_frame_r == $past(stack_ptr))
    else $error("Plain entry marked as extra stacked");
  a_extra_frame: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_extra_entry |=> arg_frame_r ==
        $past(stack_ptr) + `SBER_EXTRA_FRAME_OFS)
    else $error("Extra stacking frame offset wrong");
  a_ret_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    exc_take |=>
        exception_return_code_r[`SBER_EXR_MODE_POS] == $past(ret_mode_thread) &&
        exception_return_code_r[`SBER_EXR_SPSEL_POS] == $past(ret_spsel_psp))
    else $error("Return code mode or stack bit wrong");
  a_ret_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !exc_take |=> $stable(exception_return_code_r) && $stable(arg_frame_r))
    else $error("Return code changed without entry");
  a_pend_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PCLR_POS] &&
    !interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS] && !interrupt_control_state_register_wr.from_sec
    |=> !serv_pend_r[1])
    else $error("Non-secure pend clear lost");
  a_pend_alias: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS] &&
    interrupt_control_state_register_wr.from_sec && interrupt_control_state_register_wr.ns_alias |=> serv_pend_r[1])
    else $error("Alias pend set did not reach non-secure bank");
  a_pend_sec: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && interrupt_control_state_register_wr.wdata[`SBER_INTERRUPT_CONTROL_STATE_REGISTER_PSET_POS] &&
    interrupt_control_state_register_wr.from_sec && !interrupt_control_state_register_wr.ns_alias |=> serv_pend_r[0])
    else $error("Secure pend set lost");
  a_pri_ns: assert property (@(posedge ref_clk) disable iff (!resetn)
    pri_we && pri_ns |=> pri_call_ns_r == $past(pri_call) &&
        pri_serv_ns_r == $past(pri_serv))
    else $error("Non-secure priority not stored");
  a_pri_sec: assert property (@(posedge ref_clk) disable iff (!resetn)
    pri_we && !pri_ns |=> pri_call_sec_r == $past(pri_call) &&
        pri_serv_sec_r == $past(pri_serv) && $stable(pri_call_ns_r))
    else $error("Secure priority write misrouted");
  a_ttns_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
    interrupt_control_state_register_wr.we && !(interrupt_control_state_register_wr.from_sec && !interrupt_control_state_register_wr.ns_alias && !TWO_TICKS)
    |=> $stable(ttns_r))
    else $error("Target bit written from a refused access");
  a_tick_dual: assert property (@(posedge ref_clk) disable iff (!resetn)
    TWO_TICKS |=>
        tick_exc_r == $past({tick_ns_event, tick_sec_event}))
    else $error("Dual tick raised in the wrong state");
  a_tick_home: assert property (@(posedge ref_clk) disable iff (!resetn)
    !TWO_TICKS && tick_sec_event && !ttns_r |=> tick_exc_r == 2'h1)
    else $error("Tick left the secure state by default");
  a_chk_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !acc.valid |=> chk_r == '0)
    else $error("Check result without an access");
  a_chk_valid: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc.valid |=> chk_r.valid)
    else $error("Access went unchecked");
  a_data_unit: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc.valid && !acc.fetch
    |=> chk_r.use_ns == ($past(acc.cur_ns) && HAS_NS) &&
        chk_r.use_sec == (!$past(acc.cur_ns) && HAS_SEC))
    else $error("Data access checked by the wrong unit");
  a_one_unit: assert property (@(posedge ref_clk) disable iff (!resetn)
    chk_r.valid |-> !(chk_r.use_sec && chk_r.use_ns))
    else $error("Both protection units selected");
  a_callable_sec: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ns_callable_fetch |=> chk_r.use_sec == HAS_SEC && !chk_r.use_ns &&
        (!$past(sec_unit_fault) || !HAS_SEC || chk_r.fault_sec))
    else $error("Callable fetch not routed to secure unit");
  a_call_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    !supervisor_call_instruction |=> call_exc_r == 2'h0)
    else $error("Call exception without instruction");
endmodule

// ===== tb/sber_tb.sv
// Self-checking bench for the security-banked exception routing core.
// Assumes the default build: one tick timer, protection units in both.
`timescale 1ns/100ps
module tb;
  import sber_pkg::*;
  typedef struct {int due; int sel; logic [31:0] val;} sber_exp_t;
  logic          ref_clk, resetn, cur_ns, supervisor_call_instruction;
  logic          extra_stacking_done, exc_take, exc_to_ns, ret_mode_thread;
  logic          ret_spsel_psp, pri_we, pri_ns, tick_sec_event;
  logic          tick_ns_event, sec_unit_fault, ns_unit_fault;
  logic          service_taken_sec, service_taken_ns;
  logic [31:0]   stack_ptr, interrupt_control_state_register_rdata_r, exception_return_code_r, arg_frame_r;
  logic [7:0]    pri_call, pri_serv, pri_call_sec_r, pri_call_ns_r;
  logic [7:0]    pri_serv_sec_r, pri_serv_ns_r;
  logic [7:0]    pcs = '0, pcn = '0, pss = '0, psn = '0;
  logic [1:0]    call_exc_r, serv_pend_r, tick_exc_r;
  sber_interrupt_control_state_register_wr_t interrupt_control_state_register_wr;
  sber_acc_t     acc;
  sber_chk_t     chk_r;
  sber_exp_t     q[$];
  int            cyc = 0, seed = 32'h61c5, miscompares = 0, total_checks = 0;
  string         nm[8] = '{"call", "pend", "tick", "prio", "interrupt_control_state_register", "eret",
                           "frame", "chk"};
  localparam logic [31:0] S = 32'h10000000, C = 32'h08000000;
  localparam logic [31:0] T = 32'h01000000;

  sber_core sber_core_inst (.ref_clk, .resetn, .cur_ns,
    .supervisor_call_instruction, .extra_stacking_done, .exc_take,
    .exc_to_ns, .ret_mode_thread, .ret_spsel_psp, .stack_ptr, .interrupt_control_state_register_wr,
    .pri_we, .pri_ns, .pri_call, .pri_serv, .tick_sec_event, .tick_ns_event,
    .acc, .sec_unit_fault, .ns_unit_fault, .service_taken_sec,
    .service_taken_ns, .call_exc_r, .serv_pend_r, .tick_exc_r,
    .pri_call_sec_r, .pri_call_ns_r, .pri_serv_sec_r, .pri_serv_ns_r,
    .interrupt_control_state_register_rdata_r, .exception_return_code_r, .arg_frame_r, .chk_r);

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] got(int s);
    case (s)
      0: return {30'h0, call_exc_r};
      1: return {30'h0, serv_pend_r};
      2: return {30'h0, tick_exc_r};
      3: return {pri_call_sec_r, pri_call_ns_r, pri_serv_sec_r, pri_serv_ns_r};
      4: return interrupt_control_state_register_rdata_r;
      5: return exception_return_code_r;
      6: return arg_frame_r;
      default: return {26'h0, chk_r};
    endcase
  endfunction

  // Results are due one cycle after their stimulus edge
  task automatic ex(int s, logic [31:0] v);
    q.push_back('{cyc + 1, s, v});
  endtask

  // Strobes are single-cycle, so every step drops them first
  task automatic tick();
    @(posedge ref_clk);
    #1;
    {supervisor_call_instruction, exc_take, pri_we, tick_sec_event,
     service_taken_sec, service_taken_ns, sec_unit_fault, ns_unit_fault} = '0;
    interrupt_control_state_register_wr.we = 1'b0;
    acc.valid = 1'b0;
  endtask

  task automatic interrupt_control_state_register(logic w, logic fs, logic al, logic [31:0] d);
    tick();
    interrupt_control_state_register_wr = '{we: w, from_sec: fs, ns_alias: al, wdata: d};
  endtask

  task automatic chk_acc(logic f, logic c, logic an, logic sf, logic nf,
                         logic [31:0] a, logic [5:0] e);
    tick();
    acc = '{valid: 1'b1, fetch: f, write: ~f, priv: 1'b1, cur_ns: c,
            addr_ns: an, addr: a};
    sec_unit_fault = sf;
    ns_unit_fault = nf;
    ex(7, {26'h0, e});
  endtask

  initial begin : mon
    sber_exp_t e;
    forever begin
      @(posedge ref_clk);
      cyc++;
      #2;
      while (q.size() > 0 && q[0].due <= cyc) begin
        e = q.pop_front();
        chk(nm[e.sel], e.val, got(e.sel));
      end
    end
  end

  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    {resetn, cur_ns, supervisor_call_instruction, extra_stacking_done,
     exc_take, exc_to_ns, ret_mode_thread, ret_spsel_psp, pri_we, pri_ns,
     tick_sec_event, tick_ns_event, sec_unit_fault, ns_unit_fault,
     service_taken_sec, service_taken_ns} = '0;
    {stack_ptr, pri_call, pri_serv} = '0;
    interrupt_control_state_register_wr = '0;
    acc = '0;
    repeat (6) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    for (int s = 0; s < 8; s++) ex(s, 32'h0);
    for (int i = 0; i < 2; i++) begin
      tick();
      cur_ns = i[0];
      supervisor_call_instruction = 1'b1;
      ex(0, i[0] ? 32'h2 : 32'h1);
    end
    interrupt_control_state_register(1, 1, 0, S); ex(1, 32'h1);
    interrupt_control_state_register(1, 1, 1, S); ex(1, 32'h3);
    interrupt_control_state_register(0, 0, 0, 0); ex(4, S);
    tick(); service_taken_sec = 1'b1; ex(1, 32'h2);
    interrupt_control_state_register(0, 1, 0, 0); ex(4, 32'h0);
    interrupt_control_state_register(1, 0, 0, S | C); ex(1, 32'h2);
    tick(); service_taken_ns = 1'b1; ex(1, 32'h0);
    interrupt_control_state_register(1, 1, 1, S); ex(1, 32'h2);
    interrupt_control_state_register(1, 0, 0, C); ex(1, 32'h0);
    interrupt_control_state_register(1, 0, 0, T);
    interrupt_control_state_register(1, 1, 1, T);
    interrupt_control_state_register(0, 1, 0, 0); ex(4, 32'h0);
    tick(); tick_sec_event = 1'b1; ex(2, 32'h1);
    interrupt_control_state_register(1, 1, 0, T);
    interrupt_control_state_register(0, 1, 0, 0); ex(4, T);
    interrupt_control_state_register(0, 0, 0, 0); ex(4, 32'h0);
    tick(); tick_sec_event = 1'b1; ex(2, 32'h2);
    for (int k = 0; k < 4; k++) begin
      tick();
      pri_we = 1'b1;
      pri_ns = k[0];
      pri_call = 8'($random(seed));
      pri_serv = 8'($random(seed));
      if (k[0]) {pcn, psn} = {pri_call, pri_serv};
      else {pcs, pss} = {pri_call, pri_serv};
      ex(3, {pcs, pcn, pss, psn});
    end
    for (int k = 0; k < 4; k++) begin
      tick();
      {exc_take, cur_ns, exc_to_ns, extra_stacking_done} = {3'b100, k[0]};
      {ret_mode_thread, ret_spsel_psp} = 2'($random(seed));
      stack_ptr = $random(seed) & 32'hfffffff8;
      ex(5, 32'hffffffc1 | {26'h0, ~k[0], 1'b0, ret_mode_thread,
                           ret_spsel_psp, 2'b00});
      ex(6, stack_ptr + (k[0] ? 32'h40 : 32'h0));
    end
    chk_acc(0, 0, 1, 0, 1, 32'h20200000, 6'b110000);
    chk_acc(0, 1, 0, 1, 1, 32'h10000000, 6'b101010);
    chk_acc(1, 1, 0, 1, 0, 32'h101ffc00, 6'b110100);
    chk_acc(1, 0, 1, 0, 1, 32'h00200000, 6'b101010);
    chk_acc(1, 1, 0, 0, 0, 32'hfefa1250, 6'b110101);
    repeat (4) tick();
    report_and_stop();
  end
endmodule
